// ===== via_pkg.sv
package via_pkg;
   // ----------------------------------------
   // source slots (default priority order)
   // ----------------------------------------
   localparam int NUM_SRC      = 23;
   localparam int LAST_PRIO    = 22;
   localparam int SLOT_LVI     = 0;
   localparam int SLOT_PIN0    = 1;
   localparam int NUM_PINS     = 6;
   localparam int SLOT_SHARED  = 10;
   localparam int SLOT_TIMER_B = 19;
   localparam int SLOT_TWOWIRE = 22;
   localparam int FLAG_BYTE    = 8;
   localparam int SHARED_BIT   = 2;
   localparam int LVMD_BIT     = 1;
   localparam logic [7:0]  REQ_RESET   = 8'h00;
   localparam logic [7:0]  MASK_RESET  = 8'hff;
   localparam logic [15:0] VEC_RESET   = 16'h0000;
   localparam logic [15:0] VEC_BASE    = 16'h0004;
   localparam logic [15:0] VEC_BRK     = 16'h003e;
   localparam logic [15:0] VEC_TWOWIRE = 16'h0034;
   localparam logic [15:0] VEC_WATCH   = 16'h002e;

   typedef struct packed {
      logic        valid;
      logic [4:0]  slot;
      logic [15:0] vector;
   } via_grant_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_OFFER = 3'b010,
      ST_BRK  = 3'b100
   } via_state_t;
endpackage : via_pkg

// ===== via_arbiter.sv
`timescale 1ns/100ps
module via_arbiter #(
   parameter int NSRC = via_pkg::NUM_SRC
) (
   ref_clk,
   reset_n,
   src_req,
   pin_level,
   rising_edge_enables,
   falling_edge_enables,
   lowvolt_detect,
   lowvolt_control_reg,
   clocked_serial_done_req,
   uart_zero_tx_done_req,
   timer_b_match_req,
   carrier_timer_event,
   timer_b_carrier_mode,
   mask_wr,
   mask_wdata,
   prio_wr,
   prio_wdata,
   req_set,
   global_enable,
   brk_req,
   accept,
   grant,
   request_flags,
   mask_flags,
   priority_flags,
   lowvolt_reset
);
   import via_pkg::*;
   input  wire logic                 ref_clk;
   input  wire logic                 reset_n;
   input  wire logic [NSRC-1:0]      src_req;
   input  wire logic [NUM_PINS-1:0]  pin_level;
   input  wire logic [NUM_PINS-1:0]  rising_edge_enables;
   input  wire logic [NUM_PINS-1:0]  falling_edge_enables;
   input  wire logic                 lowvolt_detect;
   input  wire logic [7:0]           lowvolt_control_reg;
   input  wire logic                 clocked_serial_done_req;
   input  wire logic                 uart_zero_tx_done_req;
   input  wire logic                 timer_b_match_req;
   input  wire logic                 carrier_timer_event;
   input  wire logic                 timer_b_carrier_mode;
   input  wire logic                 mask_wr;
   input  wire logic [NSRC-1:0]      mask_wdata;
   input  wire logic                 prio_wr;
   input  wire logic [NSRC-1:0]      prio_wdata;
   input  wire logic [NSRC-1:0]      req_set;
   input  wire logic                 global_enable;
   input  wire logic                 brk_req;
   input  wire logic                 accept;
   output via_pkg::via_grant_t       grant;
   output logic [NSRC-1:0]           request_flags;
   output logic [NSRC-1:0]           mask_flags;
   output logic [NSRC-1:0]           priority_flags;
   output logic                      lowvolt_reset;

   if (NSRC != NUM_SRC) begin : g_bad_count
      $error("via_arbiter: source count must be 23");
   end
   // flag groups are whole bytes; the top byte is cut down to the source count
   localparam int NBYTES = (NSRC + FLAG_BYTE - 1) / FLAG_BYTE;
   localparam logic [NBYTES*FLAG_BYTE-1:0] REQ_WIDE  = {NBYTES{REQ_RESET}};
   localparam logic [NBYTES*FLAG_BYTE-1:0] MASK_WIDE = {NBYTES{MASK_RESET}};

   // ----------------------------------------
   // vector lookup
   // ----------------------------------------
   // slots 0..19 step by two from 0004h; 20 is unused, 21 stays on the step at 002eh, 22 is sparse
   function automatic logic [15:0] slot_vector(input logic [4:0] s);
      logic [15:0] v;
      v = VEC_BASE + {10'h000, s, 1'b0};
      if (s == 5'(LAST_PRIO)) v = VEC_TWOWIRE;
      else if (s == 5'(LAST_PRIO - 1)) v = VEC_WATCH;
      return v;
   endfunction : slot_vector

   // ----------------------------------------
   // request sources
   // ----------------------------------------
   logic [NUM_PINS-1:0] pin_prev_r;
   logic [NUM_PINS-1:0] pin_prev_nxt;
   logic [NSRC-1:0]     raw_ev;
   logic                lv_mode;
   logic [NUM_PINS-1:0] raw_ev_pin;
   // edges ignored for one cycle after reset, so a pin idling high gives no false rise
   logic                pin_armed_r;
   logic                pin_armed_nxt;

   assign lv_mode = lowvolt_control_reg[LVMD_BIT];

   always_comb begin
      pin_prev_nxt = pin_level;
      pin_armed_nxt = 1'b1;
      raw_ev = src_req;
      raw_ev[SLOT_LVI] = lowvolt_detect & ~lv_mode;
      raw_ev[SLOT_SHARED] = clocked_serial_done_req | uart_zero_tx_done_req;
      raw_ev[SLOT_TIMER_B] = timer_b_carrier_mode ? carrier_timer_event
                                                  : timer_b_match_req;
      raw_ev[LAST_PRIO - 2] = 1'b0;
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         logic rise;
         logic fall;
         assign rise = pin_level[gi] & ~pin_prev_r[gi];
         assign fall = ~pin_level[gi] & pin_prev_r[gi];
         assign raw_ev_pin[gi] = pin_armed_r & ((rise & rising_edge_enables[gi])
                                              | (fall & falling_edge_enables[gi]));
      end
   endgenerate

   // ----------------------------------------
   // flags and arbitration
   // ----------------------------------------
   logic [NSRC-1:0] req_r, req_nxt, mask_r, mask_nxt, prio_r, prio_nxt;
   via_grant_t      grant_r, grant_nxt;
   via_state_t      st_r, st_nxt;
   logic            lvr_r, lvr_nxt;
   logic [NSRC-1:0] live;
   logic            found;
   logic [4:0]      win;

   always_comb begin
      live = req_r & ~mask_r;
      found = 1'b0;
      win = '0;
      // high group first, then lowest slot inside the group
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (live[i] & prio_r[i] == 1'b0) begin
            found = 1'b1;
            win = 5'(i);
         end
      end
      if (!found) begin
         for (int i = NSRC - 1; i >= 0; i--) begin
            if (live[i]) begin
               found = 1'b1;
               win = 5'(i);
            end
         end
      end
   end

   always_comb begin
      logic [NSRC-1:0] ev;
      ev = raw_ev;
      ev[SLOT_PIN0 +: NUM_PINS] = raw_ev_pin;
      ev = ev | req_set;
      req_nxt = req_r;
      mask_nxt = mask_wr ? mask_wdata : mask_r;
      prio_nxt = prio_wr ? prio_wdata : prio_r;
      grant_nxt = grant_r;
      st_nxt = st_r;
      lvr_nxt = lowvolt_detect & lv_mode;
      case (st_r)
         ST_IDLE: begin
            if (brk_req) begin
               st_nxt = ST_BRK;
               grant_nxt = '{valid: 1'b1, slot: 5'h1f, vector: VEC_BRK};
            end else if (global_enable && found) begin
               st_nxt = ST_OFFER;
               grant_nxt = '{valid: 1'b1, slot: win, vector: slot_vector(win)};
            end
         end
         ST_OFFER: begin
            if (accept) begin
               req_nxt[grant_r.slot] = 1'b0;
               st_nxt = ST_IDLE;
               grant_nxt.valid = 1'b0;
            end else if (!global_enable) begin
               st_nxt = ST_IDLE;
               grant_nxt.valid = 1'b0;
            end
         end
         ST_BRK: begin
            if (accept) begin
               st_nxt = ST_IDLE;
               grant_nxt.valid = 1'b0;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
            grant_nxt.valid = 1'b0;
         end
      endcase
      // set wins over the acceptance clear
      req_nxt = req_nxt | ev;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_r <= REQ_WIDE[NSRC-1:0];
         mask_r <= MASK_WIDE[NSRC-1:0];
         prio_r <= MASK_WIDE[NSRC-1:0];
         grant_r <= '{valid: 1'b0, slot: 5'h00, vector: VEC_RESET};
         st_r <= ST_IDLE;
         lvr_r <= 1'b0;
         pin_prev_r <= '0;
         pin_armed_r <= 1'b0;
      end else begin
         req_r <= req_nxt;
         mask_r <= mask_nxt;
         prio_r <= prio_nxt;
         grant_r <= grant_nxt;
         st_r <= st_nxt;
         lvr_r <= lvr_nxt;
         pin_prev_r <= pin_prev_nxt;
         pin_armed_r <= pin_armed_nxt;
      end
   end

   assign grant = grant_r;
   assign request_flags = req_r;
   assign mask_flags = mask_r;
   assign priority_flags = prio_r;
   assign lowvolt_reset = lvr_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_mask_reset;
      @(posedge ref_clk) $rose(reset_n) |-> mask_r == {NSRC{1'b1}} && req_r == '0;
   endproperty
   a_mask_reset: assert property (p_mask_reset) else $error("flags not reset");

   property p_lv_reset;
      @(posedge ref_clk) disable iff (!reset_n)
         lowvolt_detect && lowvolt_control_reg[LVMD_BIT] && !req_set[SLOT_LVI]
         |=> lowvolt_reset && !$rose(req_r[SLOT_LVI]);
   endproperty
   a_lv_reset: assert property (p_lv_reset) else $error("low-voltage not a reset");

   property p_lv_irq;
      @(posedge ref_clk) disable iff (!reset_n)
         lowvolt_detect && !lowvolt_control_reg[LVMD_BIT] |=> req_r[0] && !lowvolt_reset;
   endproperty
   a_lv_irq: assert property (p_lv_irq) else $error("low-voltage not a request");

   property p_shared;
      @(posedge ref_clk) disable iff (!reset_n)
         uart_zero_tx_done_req || clocked_serial_done_req |=> req_r[SLOT_SHARED];
   endproperty
   a_shared: assert property (p_shared) else $error("shared flag not set");

   property p_twowire_vec;
      @(posedge ref_clk) disable iff (!reset_n)
         grant_r.valid && grant_r.slot == 5'(SLOT_TWOWIRE) |-> grant_r.vector == VEC_TWOWIRE;
   endproperty
   a_twowire_vec: assert property (p_twowire_vec) else $error("two-wire vector wrong");

   property p_clear_on_accept;
      @(posedge ref_clk) disable iff (!reset_n)
         st_r == ST_OFFER && accept && !req_set[grant_r.slot] && !raw_ev[grant_r.slot]
         && !(grant_r.slot >= 5'(SLOT_PIN0) && grant_r.slot < 5'(SLOT_PIN0 + NUM_PINS))
         |=> !req_r[$past(grant_r.slot)];
   endproperty
   a_clear_on_accept: assert property (p_clear_on_accept) else $error("flag kept");

   property p_brk;
      @(posedge ref_clk) disable iff (!reset_n)
         st_r == ST_IDLE && brk_req |=> grant_r.valid && grant_r.vector == VEC_BRK;
   endproperty
   a_brk: assert property (p_brk) else $error("breakpoint not taken");

   property p_masked_never;
      @(posedge ref_clk) disable iff (!reset_n)
         st_r == ST_IDLE && !brk_req && global_enable && found
         |=> grant_r.valid && (!mask_r[grant_r.slot] || $past(mask_wr));
   endproperty
   a_masked_never: assert property (p_masked_never) else $error("masked winner");
endmodule : via_arbiter

// ===== via_core_model.sv
`timescale 1ns/100ps
module via_core_model
   import via_pkg::*;
(
   ref_clk,
   reset_n,
   grant,
   stall,
   accept
);
   input  wire logic          ref_clk;
   input  wire logic          reset_n;
   input  via_pkg::via_grant_t grant;
   input  wire logic [3:0]    stall;
   output logic               accept;
   // ----------------------------------------
   // core acceptance
   // ----------------------------------------
   // a nonzero stall keeps the grant standing, which checks that it is not preempted
   logic [20:0] log_q[$];
   int          wait_n;
   always @(negedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         accept = 1'b0;
         wait_n = 0;
      end else if (accept) begin
         accept = 1'b0;
         wait_n = 0;
      end else if (grant.valid === 1'b1) begin
         if (wait_n >= int'(stall)) begin
            accept = 1'b1;
            log_q.push_back({grant.slot, grant.vector});
         end else begin
            wait_n++;
         end
      end
   end
endmodule : via_core_model

// ===== vectored_interrupt_arbiter_bench.sv
`timescale 1ns/100ps
module vectored_interrupt_arbiter_bench;
   import via_pkg::*;
   // ----------------------------------------
   // stimulus and observation
   // ----------------------------------------
   logic [22:0] src_req, mask_wdata, prio_wdata, req_set;
   logic [22:0] request_flags, mask_flags, priority_flags;
   logic [5:0]  pin_level, rising_edge_enables, falling_edge_enables;
   logic [7:0]  lowvolt_control_reg;
   logic        ref_clk, reset_n, lowvolt_detect, clocked_serial_done_req;
   logic        uart_zero_tx_done_req, timer_b_match_req, carrier_timer_event;
   logic        timer_b_carrier_mode, mask_wr, prio_wr, global_enable, brk_req;
   logic        accept, lowvolt_reset;
   logic [3:0]  stall;
   via_grant_t  grant;
   int          failures, n_tests;
   via_arbiter dut (
      .ref_clk                 (ref_clk),
      .reset_n                 (reset_n),
      .src_req                 (src_req),
      .pin_level               (pin_level),
      .rising_edge_enables     (rising_edge_enables),
      .falling_edge_enables    (falling_edge_enables),
      .lowvolt_detect          (lowvolt_detect),
      .lowvolt_control_reg     (lowvolt_control_reg),
      .clocked_serial_done_req (clocked_serial_done_req),
      .uart_zero_tx_done_req   (uart_zero_tx_done_req),
      .timer_b_match_req       (timer_b_match_req),
      .carrier_timer_event     (carrier_timer_event),
      .timer_b_carrier_mode    (timer_b_carrier_mode),
      .mask_wr                 (mask_wr),
      .mask_wdata              (mask_wdata),
      .prio_wr                 (prio_wr),
      .prio_wdata              (prio_wdata),
      .req_set                 (req_set),
      .global_enable           (global_enable),
      .brk_req                 (brk_req),
      .accept                  (accept),
      .grant                   (grant),
      .request_flags           (request_flags),
      .mask_flags              (mask_flags),
      .priority_flags          (priority_flags),
      .lowvolt_reset           (lowvolt_reset)
   );
   via_core_model core (
      .ref_clk                 (ref_clk),
      .reset_n                 (reset_n),
      .grant                   (grant),
      .stall                   (stall),
      .accept                  (accept)
   );
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task chk(input logic [22:0] seen, input logic [22:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task close_out;
      $display("failures %0d comparisons %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   // bounded wait for the next accepted grant; a hang ends the run
   task expect_grant(input logic [4:0] s, input logic [15:0] v);
      int k;
      k = 0;
      while (core.log_q.size() == 0 && k < 60) begin
         cyc(1);
         k++;
      end
      if (core.log_q.size() == 0) begin
         failures++;
         close_out();
      end else begin
         chk(core.log_q.pop_front(), {s, v});
      end
   endtask : expect_grant
   task quiet(input int n);
      cyc(n);
      chk(23'(core.log_q.size()), 23'h0);
   endtask : quiet
   initial begin
      {src_req, mask_wdata, prio_wdata, req_set, pin_level} = '0;
      {rising_edge_enables, falling_edge_enables, lowvolt_control_reg} = '0;
      {reset_n, lowvolt_detect, clocked_serial_done_req, uart_zero_tx_done_req} = '0;
      {timer_b_match_req, carrier_timer_event, timer_b_carrier_mode} = '0;
      {mask_wr, prio_wr, global_enable, brk_req, stall, failures, n_tests} = '0;
      cyc(6);
      reset_n = 1'b1;
      chk(request_flags, 23'h000000);
      chk(mask_flags, 23'h7fffff);
      chk(priority_flags, 23'h7fffff);
      prio_wdata = 23'h7fffff;
      {mask_wr, prio_wr, global_enable, stall} = {3'h7, 4'h3};
      cyc(1);
      {mask_wr, prio_wr} = 2'h0;
      req_set = 23'h601020;
      cyc(1);
      req_set = 23'h0;
      expect_grant(5'h05, 16'h000e);
      expect_grant(5'h0c, 16'h001c);
      expect_grant(5'h15, 16'h002e);
      expect_grant(5'h16, 16'h0034);
      cyc(2);
      chk(request_flags, 23'h000000);
      {prio_wdata, prio_wr, req_set} = {23'h3fffff, 1'b1, 23'h400020};
      cyc(1);
      {prio_wr, req_set, stall} = '0;
      expect_grant(5'h16, 16'h0034);
      expect_grant(5'h05, 16'h000e);
      clocked_serial_done_req = 1'b1;
      cyc(1);
      clocked_serial_done_req = 1'b0;
      expect_grant(5'h0a, 16'h0018);
      {mask_wdata, mask_wr, uart_zero_tx_done_req} = {23'h000400, 2'h3};
      cyc(1);
      {mask_wr, uart_zero_tx_done_req} = 2'h0;
      quiet(10);
      chk(request_flags, 23'h000400);
      // shared slot joins the high group while a higher default slot arrives
      {mask_wdata, prio_wdata, req_set} = {23'h0, 23'h7ffbff, 23'h000200};
      {mask_wr, prio_wr} = 2'h3;
      cyc(1);
      {mask_wr, prio_wr, req_set} = '0;
      chk(priority_flags, 23'h7ffbff);
      expect_grant(5'h0a, 16'h0018);
      expect_grant(5'h09, 16'h0016);
      lowvolt_detect = 1'b1;
      cyc(1);
      lowvolt_detect = 1'b0;
      chk(lowvolt_reset, 1'b0);
      expect_grant(5'h00, 16'h0004);
      {lowvolt_control_reg, lowvolt_detect} = {8'h02, 1'b1};
      cyc(1);
      lowvolt_detect = 1'b0;
      chk(lowvolt_reset, 1'b1);
      quiet(4);
      chk(lowvolt_reset, 1'b0);
      chk(request_flags, 23'h000000);
      {timer_b_carrier_mode, timer_b_match_req} = 2'h3;
      cyc(1);
      timer_b_match_req = 1'b0;
      quiet(5);
      carrier_timer_event = 1'b1;
      cyc(1);
      carrier_timer_event = 1'b0;
      expect_grant(5'h13, 16'h002a);
      {timer_b_carrier_mode, timer_b_match_req} = 2'h1;
      cyc(1);
      timer_b_match_req = 1'b0;
      expect_grant(5'h13, 16'h002a);
      {rising_edge_enables, falling_edge_enables, pin_level} = {6'h01, 6'h20, 6'h3f};
      expect_grant(5'h01, 16'h0006);
      quiet(5);
      pin_level = 6'h00;
      expect_grant(5'h06, 16'h0010);
      quiet(3);
      {global_enable, req_set} = {1'b0, 23'h000008};
      cyc(1);
      {brk_req, req_set} = {1'b1, 23'h0};
      cyc(1);
      brk_req = 1'b0;
      expect_grant(5'h1f, 16'h003e);
      quiet(5);
      chk(request_flags, 23'h000008);
      global_enable = 1'b1;
      expect_grant(5'h03, 16'h000a);
      close_out();
   end
endmodule : vectored_interrupt_arbiter_bench
